// >>> core/sleep_cal_pkg.sv
package sleep_cal_pkg;

    // ************************************************
    // Register indices (byte address is four times)
    // ************************************************
    localparam logic [9:0] IDX_LP_SOURCE    = 10'h207;
    localparam logic [9:0] IDX_CAL_LOW      = 10'h209;
    localparam logic [9:0] IDX_CAL_MID      = 10'h20A;
    localparam logic [9:0] IDX_CAL_HIGH     = 10'h20B;
    localparam logic [9:0] IDX_RADIO_STATE  = 10'h20F;
    localparam logic [9:0] IDX_STRENGTH     = 10'h210;
    localparam logic [9:0] IDX_CTRL_A       = 10'h211;
    localparam logic [9:0] IDX_CTRL_B       = 10'h220;
    localparam logic [9:0] IDX_WAKE_LOW     = 10'h222;
    localparam logic [9:0] IDX_WAKE_HIGH    = 10'h223;

    // ************************************************
    // Field positions
    // ************************************************
    localparam int CAL_READY_BIT    = 7;
    localparam int CAL_START_BIT    = 4;
    localparam int IRQ_EDGE_BIT     = 1;
    localparam int LP_DISABLE_BIT   = 0;
    localparam int CLOCK_OUTPUT_PIN_DIS_BIT   = 5;
    localparam int RADIO_STATE_LSB  = 5;
    localparam int LP_SOURCE_LSB    = 6;

    // ************************************************
    // Reset values and codes
    // ************************************************
    localparam logic [10:0] WAKE_MATCH_RESET = 11'h00A;
    localparam logic [4:0]  LP_DIV_RESET     = 5'h00;
    localparam logic [1:0]  LP_SRC_INTERNAL  = 2'h2;
    localparam logic [1:0]  LP_SRC_CRYSTAL   = 2'h1;
    localparam logic [4:0]  CAL_PERIODS      = 5'h10;

    // ************************************************
    // Timing
    // ************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS       = 50;
    localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        CAL_IDLE,
        CAL_ALIGN,
        CAL_COUNT
    } cal_state_e;

    // True when an APB byte address selects a register index
    function automatic logic hits(input logic [11:0] addr, input logic [9:0] idx);
        hits = (addr[11:2] == idx);
    endfunction

endpackage

// >>> core/lp_clock_divider.sv
`timescale 1ns/1ps
`default_nettype none
module lp_clock_divider
    import sleep_cal_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       src_edge,
    input  wire logic [4:0] div_n,
    input  wire logic       stop,
    output logic            lp_tick
);

    logic [31:0] cnt_r;
    logic [31:0] top;

    // Terminal count of a divide by two to the n
    assign top = (32'h1 << div_n) - 32'h1;

    // ************************************************
    // Divider
    // ************************************************
    // Stopped clock also clears the phase, so a restart is clean
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r   <= 32'h0;
            lp_tick <= 1'b0;
        end
        else if (stop)
        begin
            cnt_r   <= 32'h0;
            lp_tick <= 1'b0;
        end
        else
        begin
            lp_tick <= 1'b0;
            if (src_edge)
            begin
                if (cnt_r >= top)
                begin
                    cnt_r   <= 32'h0;
                    lp_tick <= 1'b1;
                end
                else
                begin
                    cnt_r <= cnt_r + 32'h1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// >>> core/sleep_cal_wake.sv
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Writing one to start bit launches calibration; hardware clears the bit.
// - Ready flag goes high once the calibration count is finished.
// - Count sixteen sleep clock periods in 50 ns ticks.
// - Result is 20 bits; top four bits sit in status bits 3..0.
// - Measured period is selected source after the programmed divider.
// - Bits 7..5 of radio state register report the radio state code.
// - Read-only byte presents averaged signal strength.
// - Polarity bit set gives rising interrupt edge, clear gives falling.
// - Sleep clock bit zero keeps clock running, one stops it.
// - Sleep clock divided by two to the 5-bit divider value, reset zero.
// - Compare 11-bit wake match with main counter, signal oscillator wake.
// - Wake match resets to ten; software never programs below one.
// - Source code 10 picks internal oscillator, 01 the crystal.
// - Low sixteen result bits readable at two byte registers, low first.
module sleep_cal_wake
    import sleep_cal_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        osc_internal,
    input  wire logic        osc_crystal,
    input  wire logic [2:0]  radio_state_code,
    input  wire logic [7:0]  strength_average,
    input  wire logic [25:0] sleep_main_counter,
    input  wire logic        irq_event,
    output logic             irq_pin,
    output logic             wake_main_osc,
    output logic             clock_output_enable,
    output logic             low_power_clock_run
);

    // ************************************************
    // Register state
    // ************************************************
    logic [1:0]  lp_source_r;
    logic [1:0]  cal_resv_r;
    logic        cal_start_r;
    logic        cal_ready_r;
    logic [19:0] cal_result_r;
    logic        irq_edge_r;
    logic        lp_disable_r;
    logic        clock_output_pin_dis_r;
    logic [4:0]  lp_div_r;
    logic [10:0] wake_match_r;

    // Calibration engine
    cal_state_e  cal_state_r;
    logic [19:0] cal_count_r;
    logic [4:0]  cal_periods_r;
    logic [2:0]  tick_div_r;
    logic        tick50;

    // Source edge detect and divided sleep clock
    logic        osc_int_d_r;
    logic        osc_xtal_d_r;
    logic        src_edge;
    logic        lp_tick;
    logic        wake_hit;
    logic        wake_hit_d_r;

    // Bus decode
    logic        access;
    logic        wr_en;
    logic        mapped;
    logic [7:0]  rd_byte;

    // ************************************************
    // APB slave
    // ************************************************
    // One wait state so read data can come from a flop
    assign access = psel & penable;
    assign wr_en  = access & pready & pwrite;

    // Address decode and read mux
    always_comb
    begin
        mapped  = 1'b1;
        rd_byte = 8'h00;
        if (hits(paddr, IDX_LP_SOURCE))
            rd_byte = {lp_source_r, 6'h00};
        else if (hits(paddr, IDX_CAL_LOW))
            rd_byte = cal_result_r[7:0];
        else if (hits(paddr, IDX_CAL_MID))
            rd_byte = cal_result_r[15:8];
        else if (hits(paddr, IDX_CAL_HIGH))
            rd_byte = {cal_ready_r, cal_resv_r, cal_start_r,
                       cal_result_r[19:16]};
        else if (hits(paddr, IDX_RADIO_STATE))
            rd_byte = {radio_state_code, 5'h00};
        else if (hits(paddr, IDX_STRENGTH))
            rd_byte = strength_average;
        else if (hits(paddr, IDX_CTRL_A))
            rd_byte = {6'h00, irq_edge_r, lp_disable_r};
        else if (hits(paddr, IDX_CTRL_B))
            rd_byte = {2'h0, clock_output_pin_dis_r, lp_div_r};
        else if (hits(paddr, IDX_WAKE_LOW))
            rd_byte = wake_match_r[7:0];
        else if (hits(paddr, IDX_WAKE_HIGH))
            rd_byte = {5'h00, wake_match_r[10:8]};
        else
            mapped = 1'b0;
    end

    // Answer on the second access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= access & ~pready;
            pslverr <= access & ~pready & ~mapped;
            if (access & ~pready & ~pwrite)
                prdata <= {24'h0, rd_byte};
        end
    end

    // ************************************************
    // Control registers
    // ************************************************
    // Plain read-write fields
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lp_source_r  <= 2'h0;
            cal_resv_r   <= 2'h0;
            irq_edge_r   <= 1'b0;
            lp_disable_r <= 1'b0;
            clock_output_pin_dis_r <= 1'b0;
            lp_div_r     <= LP_DIV_RESET;
            wake_match_r <= WAKE_MATCH_RESET;
        end
        else if (wr_en)
        begin
            if (hits(paddr, IDX_LP_SOURCE))
                lp_source_r <= pwdata[LP_SOURCE_LSB +: 2];
            if (hits(paddr, IDX_CAL_HIGH))
                cal_resv_r <= pwdata[6:5];
            if (hits(paddr, IDX_CTRL_A))
            begin
                irq_edge_r   <= pwdata[IRQ_EDGE_BIT];
                lp_disable_r <= pwdata[LP_DISABLE_BIT];
            end
            if (hits(paddr, IDX_CTRL_B))
            begin
                clock_output_pin_dis_r <= pwdata[CLOCK_OUTPUT_PIN_DIS_BIT];
                lp_div_r     <= pwdata[4:0];
            end
            if (hits(paddr, IDX_WAKE_LOW))
                wake_match_r[7:0] <= pwdata[7:0];
            if (hits(paddr, IDX_WAKE_HIGH))
                wake_match_r[10:8] <= pwdata[2:0];
        end
    end

    // Start bit lives one cycle, then hardware clears it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cal_start_r <= 1'b0;
        else
            cal_start_r <= wr_en & hits(paddr, IDX_CAL_HIGH)
                           & pwdata[CAL_START_BIT];
    end

    // ************************************************
    // Sleep clock source and divider
    // ************************************************
    // Undefined source codes give no clock at all
    assign src_edge = (lp_source_r == LP_SRC_INTERNAL) ? (osc_internal & ~osc_int_d_r)
                    : (lp_source_r == LP_SRC_CRYSTAL)  ? (osc_crystal & ~osc_xtal_d_r)
                    : 1'b0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_int_d_r  <= 1'b0;
            osc_xtal_d_r <= 1'b0;
        end
        else
        begin
            osc_int_d_r  <= osc_internal;
            osc_xtal_d_r <= osc_crystal;
        end
    end

    // Divided sleep clock feeds the calibration engine
    lp_clock_divider u_div
    (
        .pclk    (pclk),
        .presetn (presetn),
        .src_edge(src_edge),
        .div_n   (lp_div_r),
        .stop    (lp_disable_r),
        .lp_tick (lp_tick)
    );

    // ************************************************
    // Calibration engine
    // ************************************************
    // 50 ns tick from the main clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tick_div_r <= 3'h0;
        else if (cal_state_r != CAL_COUNT || tick50)
            tick_div_r <= 3'h0;
        else
            tick_div_r <= tick_div_r + 3'h1;
    end

    assign tick50 = (tick_div_r == 3'(TICK_CYCLES - 1));

    // A start while busy is ignored, so the flag never races itself
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cal_state_r   <= CAL_IDLE;
            cal_count_r   <= 20'h0;
            cal_periods_r <= 5'h0;
            cal_ready_r   <= 1'b0;
            cal_result_r  <= 20'h0;
        end
        else
        begin
            unique case (cal_state_r)
                CAL_IDLE:
                begin
                    if (cal_start_r)
                    begin
                        cal_ready_r <= 1'b0;
                        cal_state_r <= CAL_ALIGN;
                    end
                end
                CAL_ALIGN:
                begin
                    // Wait for a period boundary before counting
                    if (lp_tick)
                    begin
                        cal_count_r   <= 20'h0;
                        cal_periods_r <= 5'h0;
                        cal_state_r   <= CAL_COUNT;
                    end
                end
                CAL_COUNT:
                begin
                    // Saturate rather than wrap on a very slow clock
                    if (tick50 && cal_count_r != 20'hFFFFF)
                        cal_count_r <= cal_count_r + 20'h1;
                    if (lp_tick)
                    begin
                        cal_periods_r <= cal_periods_r + 5'h1;
                        if (cal_periods_r == CAL_PERIODS - 5'h1)
                        begin
                            // A tick on the closing edge still belongs to this run
                            cal_result_r <= (tick50 && cal_count_r != 20'hFFFFF)
                                ? cal_count_r + 20'h1 : cal_count_r;
                            cal_ready_r  <= 1'b1;
                            cal_state_r  <= CAL_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ************************************************
    // Wake match and pins
    // ************************************************
    assign wake_hit = (sleep_main_counter[10:0] == wake_match_r);

    // One wake pulse per arrival at the match value
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_hit_d_r  <= 1'b0;
            wake_main_osc <= 1'b0;
        end
        else
        begin
            wake_hit_d_r  <= wake_hit;
            wake_main_osc <= wake_hit & ~wake_hit_d_r;
        end
    end

    // Idle level opposite to the active edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_pin             <= 1'b1;
            clock_output_enable <= 1'b1;
            low_power_clock_run <= 1'b1;
        end
        else
        begin
            irq_pin             <= irq_edge_r ? irq_event : ~irq_event;
            clock_output_enable <= ~clock_output_pin_dis_r;
            low_power_clock_run <= ~lp_disable_r;
        end
    end

endmodule
`default_nettype wire

// >>> verif/sleep_cal_wake_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sleep_cal_wake_sva
    import sleep_cal_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [2:0]  radio_state_code,
    input wire logic [7:0]  strength_average,
    input wire logic [25:0] sleep_main_counter,
    input wire logic        irq_event,
    input wire logic        irq_pin,
    input wire logic        wake_main_osc,
    input wire logic        clock_output_enable,
    input wire logic        low_power_clock_run
);
    // ************************************************
    // Address decode
    // ************************************************
    logic mapped;
    logic rd_hit;

    // Mapped indices only; anything else must be refused
    assign mapped = paddr[11:2] inside {IDX_LP_SOURCE, IDX_CAL_LOW, IDX_CAL_MID, IDX_CAL_HIGH,
        IDX_RADIO_STATE, IDX_STRENGTH, IDX_CTRL_A, IDX_CTRL_B, IDX_WAKE_LOW, IDX_WAKE_HIGH};
    assign rd_hit = pready && psel && !pwrite;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ************************************************
    // Properties
    // ************************************************
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_PREADY_SOON: assert property (psel && penable && !pready |-> ##[1:2] pready)
        else $error("access phase not answered in time");
    AST_PREADY_CAUSE: assert property (pready |-> $past(psel && penable))
        else $error("pready without an access phase");
    AST_ERR_MAP: assert property (pready |-> pslverr == !mapped)
        else $error("error response does not match the address map");
    AST_UNMAPPED_ZERO: assert property (rd_hit && !mapped |-> prdata == 32'h0)
        else $error("unmapped read returned data");
    AST_RADIO_READ: assert property (
        rd_hit && paddr[11:2] == IDX_RADIO_STATE |-> prdata == {24'h0, radio_state_code, 5'h00})
        else $error("radio state read wrong");
    AST_STRENGTH_READ: assert property (
        rd_hit && paddr[11:2] == IDX_STRENGTH |-> prdata == {24'h0, strength_average})
        else $error("signal strength read wrong");
    AST_IRQ_FOLLOW: assert property ($changed(irq_event) |=> $changed(irq_pin))
        else $error("interrupt pin did not follow event");
    AST_WAKE_ONCE: assert property (wake_main_osc |=> !wake_main_osc)
        else $error("wake pulse longer than one cycle");
    AST_WAKE_CAUSE: assert property (
        wake_main_osc |-> $past(sleep_main_counter[10:0]) != $past(sleep_main_counter[10:0], 2))
        else $error("wake pulse without counter arrival");
    AST_RESET_LEVELS: assert property (
        $rose(presetn) |-> low_power_clock_run && clock_output_enable && irq_pin)
        else $error("outputs wrong after reset");
endmodule

bind sleep_cal_wake sleep_cal_wake_sva sva_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .radio_state_code(radio_state_code), .strength_average(strength_average),
    .sleep_main_counter(sleep_main_counter), .irq_event(irq_event), .irq_pin(irq_pin),
    .wake_main_osc(wake_main_osc), .clock_output_enable(clock_output_enable),
    .low_power_clock_run(low_power_clock_run));
`default_nettype wire

// >>> verif/host_irq_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_irq_model
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       irq_pin,
    input  wire logic       rise_sel,
    output logic      [7:0] seen
);
    logic last_r;

    // Host edge detector, sensitive only to the configured edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_r <= 1'h1;
            seen   <= 8'h00;
        end
        else
        begin
            last_r <= irq_pin;
            if (rise_sel ? (irq_pin && !last_r) : (!irq_pin && last_r))
                seen <= seen + 8'h01;
        end
    end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import sleep_cal_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_event, rise_sel;
    logic        osc_internal, osc_crystal, irq_pin, wake_main_osc, clock_output_enable;
    logic        low_power_clock_run, err_bit;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [2:0]  radio_state_code;
    logic [7:0]  strength_average, seen;
    logic [25:0] sleep_main_counter;
    int          err_total, comparisons, ph, wake_seen, w0;

    sleep_cal_wake sleep_cal_wake_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .osc_internal(osc_internal),
        .osc_crystal(osc_crystal), .radio_state_code(radio_state_code),
        .strength_average(strength_average), .sleep_main_counter(sleep_main_counter),
        .irq_event(irq_event), .irq_pin(irq_pin), .wake_main_osc(wake_main_osc),
        .clock_output_enable(clock_output_enable), .low_power_clock_run(low_power_clock_run));
    host_irq_model host_irq_model_i (.pclk(pclk), .presetn(presetn), .irq_pin(irq_pin),
        .rise_sel(rise_sel), .seen(seen));

    // ************************************************
    // Clock, sleep oscillators, wake monitor
    // ************************************************
    initial
    begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end

    // Periods of 40 and 20 cycles keep the expected counts whole
    always @(posedge pclk)
    begin
        ph <= ph + 1;
        osc_internal <= (ph % 40) < 20;
        osc_crystal <= (ph % 20) < 10;
        if (wake_main_osc === 1'h1) wake_seen <= wake_seen + 1;
    end

    // ************************************************
    // Bus and compare tasks
    // ************************************************
    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d,
                       output logic [31:0] rdat, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= {idx, 2'h0};
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'h1 && n < 20);
        rdat = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        if (pready !== 1'h1) err_total++;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] x;
        logic        e;
        apb(1'h1, idx, d, x, e);
    endtask

    task automatic rd(input logic [9:0] idx, output logic [31:0] x);
        logic e;
        apb(1'h0, idx, 8'h00, x, e);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Edge phase of the 50 ns prescaler may cost one tick either way
    task automatic chk_near(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (^got === 1'hx || got + 1 < exp || got > exp + 1)
        begin
            err_total++;
            $display("unexpected count at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cal(input logic [1:0] src, input logic [4:0] div, input logic [31:0] exp);
        logic [31:0] lo, mi, hi;
        int          n;
        wr(IDX_LP_SOURCE, {src, 6'h00});
        wr(IDX_CTRL_B, {3'h0, div});
        wr(IDX_CAL_HIGH, 8'h10);
        repeat (2) @(posedge pclk);
        rd(IDX_CAL_HIGH, hi);
        chk({28'h0, hi[7:4]}, 32'h0);
        n = 0;
        while (hi[7] !== 1'h1 && n < 1500)
        begin
            rd(IDX_CAL_HIGH, hi);
            n++;
        end
        chk({31'h0, hi[7]}, 32'h1);
        rd(IDX_CAL_LOW, lo);
        rd(IDX_CAL_MID, mi);
        chk_near({12'h000, hi[3:0], mi[7:0], lo[7:0]}, exp);
    endtask

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ************************************************
    // Tests
    // ************************************************
    initial
    begin
        {presetn, psel, penable, pwrite, irq_event, rise_sel} = 6'h00;
        {paddr, pwdata, radio_state_code, sleep_main_counter} = 73'h0;
        strength_average = 8'hA5;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        chk(irq_pin & clock_output_enable & low_power_clock_run, 32'h1);
        rd(IDX_CTRL_A, r);
        chk(r, 32'h0);
        rd(IDX_CTRL_B, r);
        chk(r, 32'h0);
        rd(IDX_WAKE_LOW, r);
        chk(r, 32'h0A);
        rd(IDX_WAKE_HIGH, r);
        chk(r, 32'h0);
        for (int c = 0; c < 8; c++)
        begin
            radio_state_code <= c[2:0];
            rd(IDX_RADIO_STATE, r);
            chk(r, {24'h0, c[2:0], 5'h00});
        end
        wr(IDX_STRENGTH, 8'h00);
        rd(IDX_STRENGTH, r);
        chk(r, 32'hA5);
        wr(IDX_CTRL_A, 8'h01);
        repeat (3) @(posedge pclk);
        chk(low_power_clock_run, 32'h0);
        wr(IDX_CTRL_B, 8'h3F);
        repeat (3) @(posedge pclk);
        chk(clock_output_enable, 32'h0);
        rd(IDX_CTRL_B, r);
        chk(r, 32'h3F);
        irq_event <= 1'h1;
        repeat (3) @(posedge pclk);
        chk(irq_pin, 32'h0);
        irq_event <= 1'h0;
        wr(IDX_CTRL_A, 8'h02);
        rise_sel <= 1'h1;
        repeat (2) @(posedge pclk);
        irq_event <= 1'h1;
        repeat (3) @(posedge pclk);
        chk(irq_pin & low_power_clock_run, 32'h1);
        irq_event <= 1'h0;
        repeat (3) @(posedge pclk);
        chk(seen, 32'h2);
        apb(1'h0, 10'h300, 8'h00, r, err_bit);
        chk(r, 32'h0);
        chk({31'h0, err_bit}, 32'h1);
        wr(IDX_WAKE_LOW, 8'h23);
        wr(IDX_WAKE_HIGH, 8'h01);
        sleep_main_counter <= 26'h0800122;
        repeat (4) @(posedge pclk);
        w0 = wake_seen;
        sleep_main_counter <= 26'h0800123;
        repeat (8) @(posedge pclk);
        chk(32'(wake_seen - w0), 32'h1);
        cal(LP_SRC_INTERNAL, 5'h01, 32'h100);
        cal(LP_SRC_INTERNAL, 5'h02, 32'h200);
        cal(LP_SRC_CRYSTAL, 5'h02, 32'h100);
        finish_test();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        repeat (40000) @(posedge pclk);
        err_total++;
        finish_test();
    end
endmodule
`default_nettype wire
